// [design/pas_regs_top.sv]
// Contract
// - luma gain is field over 32
// - luma offset is signed brightness add
// - peaking intensity is field over 16
// - three-line smoothing, zero passes centre
// - smoothing above 21 accepted, not clamped
// - chroma gain is field over 32
// - output pins follow register; reads return written
// - nonzero upper output byte enters test mode
// - controller owns output bit 0 while enabled
// - reset bit restarts controller, self-clears
// - disabled controller runs no task; reset and clear bits still act
// - test image bit selects colour bars
// - clear bit drops mode-done flag, self-clears
// - redetect bit remeasures and recalibrates
// - recalibrate bit clears table entry too
// - recompute bit recalculates pipeline, self-clears
// - table enable stores calibration per mode
// - bypass bits stop calibration or detection sampling
// - centre bit centres small images
// - manual calibration flag consumed then cleared
// - normalised level translated to smoothing coefficient
// - mode-done set after calculations, held until cleared
`include "pas_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pas_regs_top (
    // Clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_b_in,
    // Register port
    input  wire logic [7:0]            reg_addr_in,
    input  wire logic [7:0]            reg_wdata_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    output logic [7:0]                 reg_rdata_out,
    // Input timing measurements
    input  wire logic [10:0]           input_line_clock_count_in,
    input  wire logic [10:0]           input_frame_line_count_in,
    // Video
    input  wire pas_pkg::pas_pix_type  pix_in,
    input  wire logic                  pix_valid_in,
    input  wire logic [7:0]            above_luma_in,
    input  wire logic [7:0]            below_luma_in,
    input  wire logic [10:0]           pixel_x_in,
    output pas_pkg::pas_pix_type       pix_out,
    output logic                       pix_valid_out,
    // Pins and status
    output logic [7:0]                 general_output_bits_out,
    output logic                       test_mode_out,
    output logic                       mode_change_done_out,
    output logic                       center_small_image_out,
    output logic                       calibration_valid_out
);
    import pas_pkg::*;
    pas_top_state_type s, n;
    pas_coef_type      coef;
    logic              enab;
    logic              fin;
    logic              moved;
    logic              calib_skip;

    // Controller conditions
    assign enab  = s.cmd_lo[`PAS_B_ENABLE];
    assign fin   = enab && !s.cmd_lo[`PAS_B_SWRST] && s.st == PAS_COMPUTE
                && s.cnt == 8'h00;
    assign moved = !s.cmd_hi[`PAS_B_MDBYP]
                && (input_line_clock_count_in != s.input_line_clock_count
                    || input_frame_line_count_in != s.input_frame_line_count);
    // A stored table entry lets calibration finish at once
    assign calib_skip = s.cmd_hi[`PAS_B_CALBYP]
                     || (s.cmd_lo[`PAS_B_TBLEN] && s.tbl[s.mode]);

    // Coefficients steer the pixel path directly
    assign coef = '{s.luma_gain, s.luma_offset, s.peak, s.smooth,
                    s.chroma_gain, s.cmd_lo[`PAS_B_TESTIMG]};

    // Controller first, then host writes, so a host write wins its cycle
    always_comb begin
        n       = s;
        n.rdata = `PAS_RST_BYTE;
        if (s.cmd_lo[`PAS_B_CLRMD]) begin
            n.mdone                = 1'b0;
            n.cmd_lo[`PAS_B_CLRMD] = 1'b0;
        end
        if (s.cmd_lo[`PAS_B_SWRST]) begin
            n.st                   = PAS_IDLE;
            n.cnt                  = 8'h00;
            n.tbl                  = 8'h00;
            n.cal_ok               = 1'b0;
            n.cmd_lo[`PAS_B_SWRST] = 1'b0;
        end else if (!enab) begin
            n.st = PAS_IDLE;
        end else begin
            unique case (s.st)
                PAS_IDLE: begin
                    if (s.cmd_hi[`PAS_B_MCALNEW]) begin
                        n.cal_ok                = 1'b1;
                        n.cmd_hi[`PAS_B_MCALNEW] = 1'b0;
                    end else if (s.cmd_lo[`PAS_B_REDET] || moved) begin
                        n.st  = PAS_MEASURE;
                        n.cnt = `PAS_T_MEAS;
                    end else if (s.cmd_lo[`PAS_B_RECAL]) begin
                        if (s.cmd_lo[`PAS_B_TBLEN]) begin
                            n.tbl[s.mode] = 1'b0;
                        end
                        n.cal_ok = 1'b0;
                        n.st     = PAS_CALIB;
                        n.cnt    = `PAS_T_CAL;
                    end else if (s.cmd_lo[`PAS_B_RECALC]) begin
                        n.st  = PAS_COMPUTE;
                        n.cnt = `PAS_T_CALC;
                    end
                end
                PAS_MEASURE: begin
                    if (s.cnt == 8'h00) begin
                        n.input_line_clock_count                  = input_line_clock_count_in;
                        n.input_frame_line_count                  = input_frame_line_count_in;
                        n.mode                 = input_line_clock_count_in[2:0]
                                               ^ input_frame_line_count_in[2:0];
                        n.cmd_lo[`PAS_B_REDET] = 1'b0;
                        n.cal_ok               = 1'b0;
                        n.st                   = PAS_CALIB;
                        n.cnt                  = `PAS_T_CAL;
                    end else begin
                        n.cnt = s.cnt - 8'h01;
                    end
                end
                PAS_CALIB: begin
                    if (calib_skip || s.cnt == 8'h00) begin
                        if (!s.cmd_hi[`PAS_B_CALBYP]) begin
                            n.cal_ok = 1'b1;
                            if (s.cmd_lo[`PAS_B_TBLEN]) begin
                                n.tbl[s.mode] = 1'b1;
                            end
                        end
                        n.cmd_lo[`PAS_B_RECAL] = 1'b0;
                        n.st                   = PAS_COMPUTE;
                        n.cnt                  = `PAS_T_CALC;
                    end else begin
                        n.cnt = s.cnt - 8'h01;
                    end
                end
                PAS_COMPUTE: begin
                    if (s.cnt == 8'h00) begin
                        n.smooth = pas_level_to_coef(s.cmd_hi[7:4]);
                        n.cmd_lo[`PAS_B_RECALC] = 1'b0;
                        n.mdone  = 1'b1;
                        n.st     = PAS_IDLE;
                    end else begin
                        n.cnt = s.cnt - 8'h01;
                    end
                end
            endcase
        end
        // Bit 0 shows controller activity while it is enabled
        n.pins = {s.general_output_bits[7:1], enab ? (s.st != PAS_IDLE) : s.general_output_bits[0]};
        // Host writes; reserved upper bytes store nothing
        if (reg_wr_in) begin
            case (reg_addr_in)
                `PAS_A_LGAIN_LO: n.luma_gain   = reg_wdata_in[5:0];
                `PAS_A_LOFS_LO:  n.luma_offset = reg_wdata_in;
                `PAS_A_PEAK_LO:  n.peak        = reg_wdata_in[4:0];
                `PAS_A_SMTH_LO:  n.smooth      = reg_wdata_in[4:0];
                `PAS_A_CGAIN_LO: n.chroma_gain = reg_wdata_in[5:0];
                `PAS_A_GPO_LO:   n.general_output_bits         = reg_wdata_in;
                `PAS_A_GPO_HI: begin
                    if (reg_wdata_in != 8'h00) begin
                        n.test_mode = 1'b1;
                    end
                end
                `PAS_A_CMD_LO:   n.cmd_lo      = reg_wdata_in;
                `PAS_A_CMD_HI:   n.cmd_hi      = reg_wdata_in;
                default: ;
            endcase
        end
        // Reads return stored values; unmapped bytes and all upper bytes except the command high byte read zero
        if (reg_rd_in) begin
            case (reg_addr_in)
                `PAS_A_LGAIN_LO: n.rdata = {2'b00, s.luma_gain};
                `PAS_A_LOFS_LO:  n.rdata = s.luma_offset;
                `PAS_A_PEAK_LO:  n.rdata = {3'b000, s.peak};
                `PAS_A_SMTH_LO:  n.rdata = {3'b000, s.smooth};
                `PAS_A_CGAIN_LO: n.rdata = {2'b00, s.chroma_gain};
                `PAS_A_GPO_LO:   n.rdata = s.general_output_bits;
                `PAS_A_CMD_LO:   n.rdata = s.cmd_lo;
                `PAS_A_CMD_HI:   n.rdata = s.cmd_hi;
                `PAS_A_STAT_LO:  n.rdata = 8'(s.mdone) << `PAS_B_MDONE;
                default:         n.rdata = `PAS_RST_BYTE;
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s             <= '0;
            s.luma_gain   <= `PAS_RST_GAIN;
            s.chroma_gain <= `PAS_RST_GAIN;
        end else begin
            s <= n;
        end
    end

    // Pixel path
    pas_pixel_path u_path (
        .core_clk_in   (core_clk_in),
        .rst_b_in      (rst_b_in),
        .coef_in       (coef),
        .pix_in        (pix_in),
        .pix_valid_in  (pix_valid_in),
        .above_luma_in (above_luma_in),
        .below_luma_in (below_luma_in),
        .pixel_x_in    (pixel_x_in),
        .pix_out       (pix_out),
        .pix_valid_out (pix_valid_out)
    );

    // Outputs straight from state
    assign reg_rdata_out           = s.rdata;
    assign general_output_bits_out = s.pins;
    assign test_mode_out           = s.test_mode;
    assign mode_change_done_out    = s.mdone;
    assign center_small_image_out  = s.cmd_hi[`PAS_B_CENTER];
    assign calibration_valid_out   = s.cal_ok;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_test_mode;
        reg_wr_in && reg_addr_in == `PAS_A_GPO_HI && reg_wdata_in != 8'h00
            |=> test_mode_out ##1 test_mode_out;
    endproperty
    a_test_mode: assert property (p_test_mode) else $error("no test mode");

    property p_gpo_read;
        reg_wr_in && reg_addr_in == `PAS_A_GPO_LO ##1
            reg_rd_in && !reg_wr_in && reg_addr_in == `PAS_A_GPO_LO
            |=> reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty
    a_gpo_read: assert property (p_gpo_read) else $error("gpo readback");

    property p_swrst;
        s.cmd_lo[`PAS_B_SWRST] && !reg_wr_in |=> !s.cmd_lo[`PAS_B_SWRST]
            && s.st == PAS_IDLE;
    endproperty
    a_swrst: assert property (p_swrst) else $error("reset not taken");

    property p_disabled;
        !enab |=> s.st == PAS_IDLE ##1 (s.st == PAS_IDLE || $past(enab));
    endproperty
    a_disabled: assert property (p_disabled) else $error("runs disabled");

    property p_mdone_clr;
        s.cmd_lo[`PAS_B_CLRMD] && !fin |=> !mode_change_done_out;
    endproperty
    a_mdone_clr: assert property (p_mdone_clr) else $error("flag kept");

    property p_mdone_set;
        fin |=> mode_change_done_out && s.st == PAS_IDLE;
    endproperty
    a_mdone_set: assert property (p_mdone_set) else $error("flag not set");

    property p_level;
        fin && !reg_wr_in |=> s.smooth == pas_level_to_coef($past(s.cmd_hi[7:4]));
    endproperty
    a_level: assert property (p_level) else $error("level wrong");

    property p_high_zero;
        reg_rd_in && reg_addr_in == `PAS_A_LGAIN_HI |=> reg_rdata_out == 8'h00;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("upper not zero");

    property p_redet;
        enab && s.st == PAS_IDLE && s.cmd_lo[`PAS_B_REDET]
            && !s.cmd_lo[`PAS_B_SWRST] && !s.cmd_hi[`PAS_B_MCALNEW]
            |=> s.st == PAS_MEASURE ##[1:300] s.st == PAS_CALIB;
    endproperty
    a_redet: assert property (p_redet) else $error("no remeasure");
endmodule : pas_regs_top
`default_nettype wire

// [design/pas_map.svh]
`ifndef PAS_MAP_SVH
`define PAS_MAP_SVH
// Register byte addresses
`define PAS_A_LGAIN_LO  8'h26
`define PAS_A_LGAIN_HI  8'h27
`define PAS_A_LOFS_LO   8'h28
`define PAS_A_LOFS_HI   8'h29
`define PAS_A_PEAK_LO   8'h2a
`define PAS_A_PEAK_HI   8'h2b
`define PAS_A_SMTH_LO   8'h2c
`define PAS_A_SMTH_HI   8'h2d
`define PAS_A_CGAIN_LO  8'h2e
`define PAS_A_CGAIN_HI  8'h2f
`define PAS_A_GPO_LO    8'h34
`define PAS_A_GPO_HI    8'h35
`define PAS_A_CMD_LO    8'h60
`define PAS_A_CMD_HI    8'h61
`define PAS_A_STAT_LO   8'h62
// Command low byte bits
`define PAS_B_SWRST     0
`define PAS_B_ENABLE    1
`define PAS_B_TESTIMG   2
`define PAS_B_CLRMD     3
`define PAS_B_REDET     4
`define PAS_B_RECAL     5
`define PAS_B_RECALC    6
`define PAS_B_TBLEN     7
// Command high byte bits
`define PAS_B_CALBYP    0
`define PAS_B_MDBYP     1
`define PAS_B_CENTER    2
`define PAS_B_MCALNEW   3
// Status bit of mode change done
`define PAS_B_MDONE     3
// Reset values
`define PAS_RST_BYTE    8'h00
`define PAS_RST_GAIN    6'h20
// Controller task counter loads; each task lasts one cycle longer
`define PAS_T_MEAS      8'd64
`define PAS_T_CAL       8'd32
`define PAS_T_CALC      8'd16
`endif

// [design/pas_pkg.sv]
package pas_pkg;
    typedef enum logic [1:0] {
        PAS_IDLE    = 2'b00,
        PAS_MEASURE = 2'b01,
        PAS_CALIB   = 2'b10,
        PAS_COMPUTE = 2'b11
    } pas_state_type;
    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
    } pas_pix_type;
    typedef struct packed {
        logic [5:0] luma_gain;
        logic [7:0] luma_offset;
        logic [4:0] peak;
        logic [4:0] smooth;
        logic [5:0] chroma_gain;
        logic       bars;
    } pas_coef_type;
    typedef struct packed {
        logic [7:0]  d1;
        logic [7:0]  d2;
        logic [7:0]  c1;
        logic [2:0]  x1;
        pas_pix_type pix;
        logic        vld;
    } pas_path_state_type;
    typedef struct packed {
        logic [5:0]    luma_gain;
        logic [7:0]    luma_offset;
        logic [4:0]    peak;
        logic [4:0]    smooth;
        logic [5:0]    chroma_gain;
        logic [7:0]    general_output_bits;
        logic [7:0]    cmd_lo;
        logic [7:0]    cmd_hi;
        logic          test_mode;
        logic          mdone;
        pas_state_type st;
        logic [7:0]    cnt;
        logic [10:0]   input_line_clock_count;
        logic [10:0]   input_frame_line_count;
        logic [2:0]    mode;
        logic [7:0]    tbl;
        logic          cal_ok;
        logic [7:0]    pins;
        logic [7:0]    rdata;
    } pas_top_state_type;
    // Limit a signed value to 0..255
    function automatic logic [7:0] pas_clamp_u8(input logic signed [16:0] v);
        if (v < 0) return 8'h00;
        if (v > 17'sd255) return 8'hff;
        return v[7:0];
    endfunction : pas_clamp_u8
    // Limit a signed value to -128..127
    function automatic logic [7:0] pas_sat_s8(input logic signed [14:0] v);
        if (v < -15'sd128) return 8'h80;
        if (v > 15'sd127) return 8'h7f;
        return v[7:0];
    endfunction : pas_sat_s8
    // Colour bar sample for one of eight bars
    function automatic pas_pix_type pas_bar(input logic [2:0] i);
        unique case (i)
            3'h0: return '{8'heb, 8'h00};
            3'h1: return '{8'hd2, 8'hc0};
            3'h2: return '{8'haa, 8'h30};
            3'h3: return '{8'h91, 8'hd8};
            3'h4: return '{8'h6a, 8'h28};
            3'h5: return '{8'h51, 8'hd0};
            3'h6: return '{8'h29, 8'h40};
            3'h7: return '{8'h10, 8'h00};
        endcase
    endfunction : pas_bar
    // Normalised level 0..8 to raw coefficient 0..21, rounded
    function automatic logic [4:0] pas_level_to_coef(input logic [3:0] lvl);
        logic [7:0] p;
        p = (lvl > 4'h8) ? 8'd168 : 8'({4'h0, lvl} * 8'd21);
        p = p + 8'd4;
        return p[7:3];
    endfunction : pas_level_to_coef
endpackage : pas_pkg

// [design/pas_pixel_path.sv]
`timescale 1ns/1ps
`default_nettype none
module pas_pixel_path (
    // Clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_b_in,
    // Coefficients
    input  wire pas_pkg::pas_coef_type coef_in,
    // Pixel in
    input  wire pas_pkg::pas_pix_type  pix_in,
    input  wire logic                 pix_valid_in,
    input  wire logic [7:0]           above_luma_in,
    input  wire logic [7:0]           below_luma_in,
    input  wire logic [10:0]          pixel_x_in,
    // Pixel out
    output pas_pkg::pas_pix_type       pix_out,
    output logic                      pix_valid_out
);
    import pas_pkg::*;
    pas_path_state_type s, n;
    logic [6:0]         w;
    logic [14:0]        sum;
    logic [7:0]         sm;
    logic signed [10:0] edg;
    logic signed [16:0] peaking_level;
    logic [7:0]         l8;
    logic [13:0]        g;
    logic signed [11:0] gs;
    logic signed [14:0] cg;

    // Three-line smoothing, peaking, gains; oversized coefficients pass unclamped
    always_comb begin
        n   = s;
        w   = 7'd64 - {1'b0, coef_in.smooth, 1'b0};
        sum = 15'(above_luma_in) * 15'(coef_in.smooth)
            + 15'(below_luma_in) * 15'(coef_in.smooth)
            + 15'(pix_in.luma) * 15'(w);
        sm  = sum[13:6];
        edg = $signed({2'b00, s.d1, 1'b0}) - $signed({3'b000, sm})
            - $signed({3'b000, s.d2});
        peaking_level = $signed({9'h000, s.d1})
            + ((17'(edg) * $signed({12'h000, coef_in.peak})) >>> 4);
        l8  = pas_clamp_u8(peaking_level);
        g   = 14'(l8) * 14'(coef_in.luma_gain);
        gs  = $signed({3'b000, g[13:5]})
            + 12'($signed(coef_in.luma_offset));
        cg  = (15'($signed(s.c1)) * $signed({9'h000, coef_in.chroma_gain})) >>> 5;
        n.vld = pix_valid_in;
        if (pix_valid_in) begin
            n.d2 = s.d1;
            n.d1 = sm;
            n.c1 = pix_in.chroma;
            n.x1 = pixel_x_in[9:7];
            if (coef_in.bars) begin
                n.pix = pas_bar(s.x1);
            end else begin
                n.pix.luma   = pas_clamp_u8(17'(gs));
                n.pix.chroma = pas_sat_s8(cg);
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign pix_out       = s.pix;
    assign pix_valid_out = s.vld;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    // Test image replaces video for the aligned bar
    property p_bars;
        pix_valid_in && coef_in.bars |=> pix_out == pas_bar($past(s.x1));
    endproperty
    a_bars: assert property (p_bars) else $error("bar image wrong");

    // Zero coefficient keeps only the centre line
    property p_smooth_zero;
        pix_valid_in && coef_in.smooth == 5'h00 |=> s.d1 == $past(pix_in.luma);
    endproperty
    a_smooth_zero: assert property (p_smooth_zero) else $error("centre not passed");
endmodule : pas_pixel_path
`default_nettype wire

// [tb/pas_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pas_host_model (
    // Clock
    input  wire logic       core_clk_in,
    // Register port
    output logic [7:0]      reg_addr_out,
    output logic [7:0]      reg_wdata_out,
    output logic            reg_wr_out,
    output logic            reg_rd_out,
    input  wire logic [7:0] reg_rdata_in
);
    // Config command entry for the pins; that space has no port on this block
    logic [7:0] config_output_mirror;
    // Idle bus values
    initial begin
        config_output_mirror = 8'h00;
        reg_addr_out  = 8'hff;
        reg_wdata_out = 8'h00;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
    end
    // One-cycle write; released lines show inverted values, never stale ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        reg_addr_out  = a;
        reg_wdata_out = d;
        reg_wr_out    = 1'b1;
        @(negedge core_clk_in);
        reg_wr_out    = 1'b0;
        reg_addr_out  = ~a;
        reg_wdata_out = ~d;
    endtask : wr
    // One-cycle read; data is registered, so it is taken one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_in);
        reg_addr_out = a;
        reg_rd_out   = 1'b1;
        @(negedge core_clk_in);
        reg_rd_out   = 1'b0;
        reg_addr_out = ~a;
        d            = reg_rdata_in;
    endtask : rd
    // Read-modify-write of the output pins keeps bit 0 for the controller
    task automatic gpo_set(input logic [7:0] v, output logic [7:0] nv);
        logic [7:0] old;
        rd(8'h34, old);
        nv = {v[7:1], old[0]};
        config_output_mirror = nv;
        wr(8'h34, nv);
        wr(8'h35, 8'h00);
    endtask : gpo_set
endmodule : pas_host_model
`default_nettype wire

// [tb/picture_adjust_and_sw_control_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module picture_adjust_and_sw_control_regs_tb_top;
    import pas_pkg::*;
    localparam logic [7:0] RA [5] = '{8'h26, 8'h28, 8'h2a, 8'h2c, 8'h2e};
    localparam logic [7:0] RM [5] = '{8'h3f, 8'hff, 8'h1f, 8'h1f, 8'h3f};
    logic        clk, rst_b, wr, rd, pv, vo, tm, md, cs, cv;
    logic [7:0]  ad, wd, rdat, ab, bl, general_output_bits, r, o, l, c, e;
    logic [10:0] input_line_clock_count, input_frame_line_count, px;
    pas_pix_type pin, pout;
    int          mismatches, checked;
    pas_host_model host (.core_clk_in(clk), .reg_addr_out(ad), .reg_wdata_out(wd),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdat));
    pas_regs_top DUT (.core_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(ad),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
        .input_line_clock_count_in(input_line_clock_count), .input_frame_line_count_in(input_frame_line_count), .pix_in(pin),
        .pix_valid_in(pv), .above_luma_in(ab), .below_luma_in(bl), .pixel_x_in(px),
        .pix_out(pout), .pix_valid_out(vo), .general_output_bits_out(general_output_bits),
        .test_mode_out(tm), .mode_change_done_out(md), .center_small_image_out(cs),
        .calibration_valid_out(cv));
    // Clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, r);
        chk(r, exp);
    endtask : rchk
    // Brightness add with clamping to the 8-bit luma range
    function automatic logic [7:0] lum(input logic [7:0] lv, input logic [7:0] ov);
        int v;
        v = int'(lv) + int'($signed(ov));
        return (v < 0) ? 8'h00 : (v > 255) ? 8'hff : 8'(v);
    endfunction : lum
    // Constant pixel stream so the two-sample delay does not matter
    task automatic pix(input logic [7:0] pl, pc, pa, pb, el, ec);
        repeat (4) begin
            @(negedge clk);
            pin = '{pl, pc};
            ab  = pa;
            bl  = pb;
            pv  = 1'b1;
        end
        @(negedge clk);
        pv = 1'b0;
        chk(pout.luma, el);
        chk(pout.chroma, ec);
        chk({7'h00, vo}, 8'h01);
    endtask : pix
    task automatic test_done;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    // Watchdog, far beyond the several hundred cycles the tests need
    initial begin
        #200000;
        mismatches++;
        test_done();
    end
    // Main sequence
    initial begin
        rst_b = 1'b0;
        pv    = 1'b0;
        pin   = '0;
        ab    = 8'h00;
        bl    = 8'h00;
        px    = 11'h000;
        r     = 8'($urandom(32'hf6a1c5f0));
        input_line_clock_count   = 11'($urandom);
        input_frame_line_count   = 11'($urandom);
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        rchk(8'h26, 8'h20);
        rchk(8'h2e, 8'h20);
        for (int i = 0; i < 5; i++) begin
            e = 8'($urandom);
            host.wr(RA[i], e);
            host.wr(RA[i] + 8'h01, e | 8'h01);
            rchk(RA[i], e & RM[i]);
            rchk(RA[i] + 8'h01, 8'h00);
        end
        $display("register test done");
        host.wr(8'h26, 8'h20);
        host.wr(8'h2a, 8'h00);
        host.wr(8'h2c, 8'h00);
        host.wr(8'h2e, 8'h20);
        // Random brightness with unity gains; zero smoothing ignores the outer lines
        for (int i = 0; i < 10; i++) begin
            o = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'($urandom);
            l = (i == 0) ? 8'hf0 : (i == 1) ? 8'h10 : 8'($urandom);
            c = 8'($urandom);
            host.wr(8'h28, o);
            pix(l, c, 8'($urandom), 8'($urandom), lum(l, o), c);
        end
        host.wr(8'h28, 8'h00);
        host.wr(8'h26, 8'h10);
        host.wr(8'h2e, 8'h3f);
        pix(8'h40, 8'h20, 8'h00, 8'h00, 8'h20, 8'h3f);
        host.wr(8'h26, 8'h20);
        host.wr(8'h2e, 8'h20);
        host.wr(8'h2c, 8'h10);
        pix(8'h40, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00);
        host.wr(8'h2c, 8'h1f);
        pix(8'h00, 8'h00, 8'h40, 8'h40, 8'h3e, 8'h00);
        host.wr(8'h2c, 8'h00);
        px = 11'h180;
        host.wr(8'h60, 8'h04);
        pix(8'h40, 8'h55, 8'h00, 8'h00, 8'h91, 8'hd8);
        host.wr(8'h60, 8'h00);
        $display("pixel test done");
        host.gpo_set(8'($urandom), e);
        chk(general_output_bits, e);
        rchk(8'h34, e);
        $display("output pin test done");
        host.wr(8'h61, 8'h84);
        @(negedge clk);
        chk({7'h00, cs}, 8'h01);
        rchk(8'h61, 8'h84);
        host.wr(8'h60, 8'h10);
        repeat (150) @(negedge clk);
        chk({7'h00, md}, 8'h00);
        rchk(8'h60, 8'h10);
        host.wr(8'h60, 8'h12);
        for (int k = 0; k < 300 && md !== 1'b1; k++) @(negedge clk);
        chk({7'h00, md}, 8'h01);
        chk({7'h00, cv}, 8'h01);
        rchk(8'h60, 8'h02);
        rchk(8'h62, 8'h08);
        rchk(8'h2c, 8'h15);
        host.wr(8'h60, 8'h0a);
        @(negedge clk);
        chk({7'h00, md}, 8'h00);
        rchk(8'h60, 8'h02);
        host.wr(8'h60, 8'h03);
        rchk(8'h60, 8'h02);
        host.wr(8'h61, 8'h88);
        host.wr(8'h60, 8'h42);
        for (int k = 0; k < 300 && md !== 1'b1; k++) @(negedge clk);
        chk({7'h00, md}, 8'h01);
        chk({7'h00, cv}, 8'h01);
        rchk(8'h61, 8'h80);
        rchk(8'h60, 8'h02);
        $display("controller test done");
        host.wr(8'h35, 8'h00);
        chk({7'h00, tm}, 8'h00);
        host.wr(8'h35, 8'h01);
        @(negedge clk);
        chk({7'h00, tm}, 8'h01);
        rchk(8'h35, 8'h00);
        $display("test mode test done");
        test_done();
    end
endmodule : picture_adjust_and_sw_control_regs_tb_top
`default_nettype wire
